// >>> vtp_pkg.sv
package vtp_pkg;

  // Video modes
  typedef enum logic [1:0] {
    MODE_720P60  = 2'h0,
    MODE_1080P60 = 2'h1,
    MODE_2160P30 = 2'h2,
    MODE_2160P60 = 2'h3
  } mode_t;

  // Scan phases, Gray coded along active -> fp -> sync -> bp
  typedef enum logic [1:0] {
    PH_ACTIVE = 2'h0,
    PH_FRONT  = 2'h1,
    PH_SYNC   = 2'h3,
    PH_BACK   = 2'h2
  } phase_t;

  typedef enum logic [1:0] {
    PAT_BARS = 2'h0,
    PAT_ZONE = 2'h1,
    PAT_RAMP = 2'h2,
    PAT_BOX  = 2'h3
  } pattern_t;

  // Lengths of one axis, in pixels (horizontal) or lines (vertical)
  typedef struct packed {
    logic [12:0] active;
    logic [12:0] front;
    logic [12:0] sync;
    logic [12:0] back;
  } axis_t;

  // Timing bundle carried on the stream with data lanes tied off
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic hblank;
    logic vblank;
    logic de;
    logic sof;
    logic eol;
  } timing_t;

  localparam int PIX_W = 24;
  localparam int BEAT_W = 48;
  localparam int MEM_W = 32;
  localparam logic [7:0] PAD_BYTE = 8'h00;

  // Horizontal counts are in pixels; two pixels move per beat
  localparam axis_t H_720 = '{13'h0500, 13'h006E, 13'h0028, 13'h00DC};
  localparam axis_t V_720 = '{13'h02D0, 13'h0005, 13'h0005, 13'h0014};
  localparam axis_t H_1080 = '{13'h0780, 13'h0058, 13'h002C, 13'h0094};
  localparam axis_t V_1080 = '{13'h0438, 13'h0004, 13'h0005, 13'h0024};
  // 3840 active, 176/88/296 porch and sync
  localparam axis_t H_2160 = '{13'h0F00, 13'h00B0, 13'h0058, 13'h0128};
  // 2160 active, 8/10/72
  localparam axis_t V_2160 = '{13'h0870, 13'h0008, 13'h000A, 13'h0048};

  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_FB_BASE = 8'h10;
  localparam logic [7:0] REG_FRAMES = 8'h14;
  localparam int CTRL_EN = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_PAT = 4;
  localparam int IRQ_FRAME = 0;
  localparam int IRQ_VSYNC = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> video_timing_pattern_capture.sv
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - Timing drives hsync, vsync, blanking and enable off pixel clock.
// - Each blanking splits into front porch, sync pulse and back porch.
// - Pixels move only during the active interval, never in blanking.
// - 2160p30 is 3840 pixels by 2160 lines at 30 frames per second.
// - 2160p30 blanking is 176/88/296 pixels and 8/10/72 lines.
// - Software picks 720p60, 1080p60, 2160p30 or 2160p60 at run time.
// - Scanning is progressive, one whole frame per frame period.
// - Pattern source follows the tied-off timing stream, never free.
// - Patterns are color bars, zone plate, moving ramp and moving box.
// - Pixels are YUV 4:2:2 with 8 bits per component on every stream.
// - A 48-bit beat holds two 24-bit pixels, top byte of each padding.
// - Writer turns the stream into memory writes, irq after each frame.
// - Memory holds packed 16-bit-per-pixel YUYV words.
module video_timing_pattern_capture (
  // Clock and reset (mclk doubles as pixel clock here)
  input wire logic mclk,
  input wire logic rst,
  // Pattern source and frame writer reset from software GPIO
  input wire logic gpio_rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Timing and pixel stream
  output vtp_pkg::timing_t timing_out,
  output logic [vtp_pkg::BEAT_W-1:0] video_data,
  // Memory write port
  output logic mem_wvalid,
  output logic [31:0] mem_waddr,
  output logic [vtp_pkg::MEM_W-1:0] mem_wdata,
  input wire logic mem_wready,
  // Interrupt
  output logic irq
);

  // Two-flop sync of the external GPIO reset
  logic gr_s1_reg, gr_s2_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gr_s1_reg <= 1'b0;
      gr_s2_reg <= 1'b0;
    end else begin
      gr_s1_reg <= gpio_rst;
      gr_s2_reg <= gr_s1_reg;
    end
  end

  // Register file
  logic [31:0] ctrl_reg, ctrl_next, base_reg, base_next;
  logic [1:0] ist_reg, ist_next, imask_reg, imask_next;
  logic [31:0] frames_reg, frames_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic rvalid_reg, rvalid_next, irq_reg, irq_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0] ws_reg, ws_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;

  // Timing state
  vtp_pkg::phase_t hph_reg, hph_next, vph_reg, vph_next;
  logic [12:0] hcnt_reg, hcnt_next, vcnt_reg, vcnt_next;
  vtp_pkg::timing_t tim_reg, tim_next;
  logic [vtp_pkg::BEAT_W-1:0] vd_reg, vd_next;
  logic [7:0] motion_reg, motion_next;
  logic mwv_reg, mwv_next;
  logic [31:0] mwa_reg, mwa_next, mwd_reg, mwd_next, ptr_reg, ptr_next;

  vtp_pkg::mode_t mode;
  vtp_pkg::pattern_t pat;
  vtp_pkg::axis_t hax, vax;
  logic enable, frame_done, vsync_rise, stall;
  logic [12:0] hlen, vlen;

  assign mode = vtp_pkg::mode_t'(ctrl_reg[vtp_pkg::CTRL_MODE +: 2]);
  assign pat = vtp_pkg::pattern_t'(ctrl_reg[vtp_pkg::CTRL_PAT +: 2]);
  assign enable = ctrl_reg[vtp_pkg::CTRL_EN] & ~gr_s2_reg;
  // Stall the whole scan when memory back-pressures a pending word
  assign stall = mwv_reg & ~mem_wready;

  always_comb begin
    case (mode)
      vtp_pkg::MODE_720P60: begin
        hax = vtp_pkg::H_720;
        vax = vtp_pkg::V_720;
      end
      vtp_pkg::MODE_1080P60: begin
        hax = vtp_pkg::H_1080;
        vax = vtp_pkg::V_1080;
      end
      // 2160p30 and p60 share geometry; only the pixel clock differs
      default: begin
        hax = vtp_pkg::H_2160;
        vax = vtp_pkg::V_2160;
      end
    endcase
  end

  // Phase lengths; horizontal counts beats of two pixels
  always_comb begin
    case (hph_reg)
      vtp_pkg::PH_ACTIVE: hlen = {1'b0, hax.active[12:1]};
      vtp_pkg::PH_FRONT: hlen = {1'b0, hax.front[12:1]};
      vtp_pkg::PH_SYNC: hlen = {1'b0, hax.sync[12:1]};
      default: hlen = {1'b0, hax.back[12:1]};
    endcase
    case (vph_reg)
      vtp_pkg::PH_ACTIVE: vlen = vax.active;
      vtp_pkg::PH_FRONT: vlen = vax.front;
      vtp_pkg::PH_SYNC: vlen = vax.sync;
      default: vlen = vax.back;
    endcase
  end

  function automatic vtp_pkg::phase_t next_ph(vtp_pkg::phase_t p);
    case (p)
      vtp_pkg::PH_ACTIVE: next_ph = vtp_pkg::PH_FRONT;
      vtp_pkg::PH_FRONT: next_ph = vtp_pkg::PH_SYNC;
      vtp_pkg::PH_SYNC: next_ph = vtp_pkg::PH_BACK;
      default: next_ph = vtp_pkg::PH_ACTIVE;
    endcase
  endfunction

  // One YUV 4:2:2 pixel word: padding, chroma, luma
  function automatic logic [23:0] pix(logic [7:0] y, logic [7:0] c);
    pix = {vtp_pkg::PAD_BYTE, c, y};
  endfunction

  logic line_end, frame_end;
  logic [7:0] y0, y1, cb, cr;
  logic [12:0] px;
  assign line_end = (hcnt_reg == hlen - 13'h0001);
  assign frame_end = line_end && (vcnt_reg == vlen - 13'h0001)
                     && (vph_reg == vtp_pkg::PH_BACK);
  assign px = {hcnt_reg[11:0], 1'b0};

  // Pattern pixels for the current beat
  always_comb begin
    y0 = 8'h00;
    cb = 8'h80;
    cr = 8'h80;
    case (pat)
      vtp_pkg::PAT_BARS: begin
        y0 = {px[11:9], 5'h00} ^ 8'hE0;
        cb = {px[10:9], 6'h00};
        cr = {px[11], px[9], 6'h00};
      end
      vtp_pkg::PAT_ZONE: y0 = px[10:3] * vcnt_reg[10:3];
      vtp_pkg::PAT_RAMP: y0 = px[7:0] + motion_reg;
      default: begin
        y0 = ((px[10:4] - motion_reg[6:0]) < 7'h10 &&
              vcnt_reg[9:5] == motion_reg[4:0]) ? 8'hEB : 8'h10;
      end
    endcase
    y1 = y0;
  end

  // Timing generator, pattern source and frame writer
  always_comb begin
    hph_next = hph_reg;
    vph_next = vph_reg;
    hcnt_next = hcnt_reg;
    vcnt_next = vcnt_reg;
    tim_next = tim_reg;
    vd_next = vd_reg;
    motion_next = motion_reg;
    mwv_next = mwv_reg & ~mem_wready;
    mwa_next = mwa_reg;
    mwd_next = mwd_reg;
    ptr_next = ptr_reg;
    frame_done = 1'b0;
    vsync_rise = 1'b0;
    if (!enable) begin
      hph_next = vtp_pkg::PH_ACTIVE;
      vph_next = vtp_pkg::PH_ACTIVE;
      hcnt_next = 13'h0000;
      vcnt_next = 13'h0000;
      tim_next = '0;
      vd_next = '0;
      ptr_next = base_reg;
      mwv_next = 1'b0;
    end else if (!stall) begin
      if (line_end) begin
        hcnt_next = 13'h0000;
        hph_next = next_ph(hph_reg);
        if (hph_reg == vtp_pkg::PH_BACK) begin
          if (vcnt_reg == vlen - 13'h0001) begin
            vcnt_next = 13'h0000;
            vph_next = next_ph(vph_reg);
            // Progressive: one full frame per period
            if (vph_reg == vtp_pkg::PH_BACK) ptr_next = base_reg;
          end else vcnt_next = vcnt_reg + 13'h0001;
        end
      end else hcnt_next = hcnt_reg + 13'h0001;
      tim_next.hsync = (hph_reg == vtp_pkg::PH_SYNC);
      tim_next.vsync = (vph_reg == vtp_pkg::PH_SYNC);
      tim_next.hblank = (hph_reg != vtp_pkg::PH_ACTIVE);
      tim_next.vblank = (vph_reg != vtp_pkg::PH_ACTIVE);
      tim_next.de = (hph_reg == vtp_pkg::PH_ACTIVE) &&
                    (vph_reg == vtp_pkg::PH_ACTIVE);
      tim_next.sof = tim_next.de && hcnt_reg == 13'h0000 &&
                     vcnt_reg == 13'h0000;
      tim_next.eol = tim_next.de && line_end;
      vsync_rise = tim_next.vsync & ~tim_reg.vsync;
      // Pixels follow the timing stream, never free-running
      if (tim_next.de) begin
        vd_next = {pix(y1, cr), pix(y0, cb)};
        // Y0 U Y1 V, one 32-bit word per two-pixel beat
        mwd_next = {cr, y1, cb, y0};
        mwa_next = ptr_reg;
        ptr_next = ptr_reg + 32'h0000_0004;
        mwv_next = 1'b1;
      end else vd_next = '0;
      if (frame_end) begin
        motion_next = motion_reg + 8'h01;
        frame_done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hph_reg <= vtp_pkg::PH_ACTIVE;
      vph_reg <= vtp_pkg::PH_ACTIVE;
      hcnt_reg <= 13'h0000;
      vcnt_reg <= 13'h0000;
      tim_reg <= '0;
      vd_reg <= '0;
      motion_reg <= 8'h00;
      mwv_reg <= 1'b0;
      mwa_reg <= 32'h0000_0000;
      mwd_reg <= 32'h0000_0000;
      ptr_reg <= 32'h0000_0000;
    end else begin
      hph_reg <= hph_next;
      vph_reg <= vph_next;
      hcnt_reg <= hcnt_next;
      vcnt_reg <= vcnt_next;
      tim_reg <= tim_next;
      vd_reg <= vd_next;
      motion_reg <= motion_next;
      mwv_reg <= mwv_next;
      mwa_reg <= mwa_next;
      mwd_reg <= mwd_next;
      ptr_reg <= ptr_next;
    end
  end

  // AXI4-Lite slave and interrupt logic
  logic do_wr;
  logic [31:0] wmask;
  always_comb begin
    awready_next = awready_reg;
    wready_next = wready_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    arready_next = 1'b0;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    ctrl_next = ctrl_reg;
    base_next = base_reg;
    imask_next = imask_reg;
    frames_next = frames_reg + {31'h0, frame_done};
    ist_next = ist_reg;
    wmask = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}}, {8{ws_reg[0]}}};
    if (s_awvalid && awready_reg) begin
      awa_next = s_awaddr;
      aw_have_next = 1'b1;
      awready_next = 1'b0;
    end
    if (s_wvalid && wready_reg) begin
      wd_next = s_wdata;
      ws_next = s_wstrb;
      w_have_next = 1'b1;
      wready_next = 1'b0;
    end
    do_wr = aw_have_reg && w_have_reg && !bvalid_reg;
    if (do_wr) begin
      bvalid_next = 1'b1;
      bresp_next = vtp_pkg::RESP_OKAY;
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      case (awa_reg)
        vtp_pkg::REG_CTRL: ctrl_next = (ctrl_reg & ~wmask) | (wd_reg & wmask);
        vtp_pkg::REG_FB_BASE:
          base_next = (base_reg & ~wmask) | (wd_reg & wmask);
        vtp_pkg::REG_IRQ_MASK: if (ws_reg[0]) imask_next = wd_reg[1:0];
        vtp_pkg::REG_IRQ_STAT:
          if (ws_reg[0]) ist_next = ist_reg & ~wd_reg[1:0];
        vtp_pkg::REG_STATUS, vtp_pkg::REG_FRAMES: ;
        default: bresp_next = vtp_pkg::RESP_SLVERR;
      endcase
    end
    // Events win over a same-cycle clear
    ist_next[vtp_pkg::IRQ_FRAME] = ist_next[vtp_pkg::IRQ_FRAME] | frame_done;
    ist_next[vtp_pkg::IRQ_VSYNC] = ist_next[vtp_pkg::IRQ_VSYNC] | vsync_rise;
    if (bvalid_reg && s_bready) begin
      bvalid_next = 1'b0;
      awready_next = 1'b1;
      wready_next = 1'b1;
    end
    if (s_arvalid && !rvalid_reg && !arready_reg) arready_next = 1'b1;
    if (s_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = vtp_pkg::RESP_OKAY;
      case (s_araddr)
        vtp_pkg::REG_CTRL: rdata_next = ctrl_reg;
        vtp_pkg::REG_STATUS:
          rdata_next = {26'h0, vph_reg, hph_reg, tim_reg.de, enable};
        vtp_pkg::REG_IRQ_STAT: rdata_next = {30'h0, ist_reg};
        vtp_pkg::REG_IRQ_MASK: rdata_next = {30'h0, imask_reg};
        vtp_pkg::REG_FB_BASE: rdata_next = base_reg;
        vtp_pkg::REG_FRAMES: rdata_next = frames_reg;
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = vtp_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_reg && s_rready) rvalid_next = 1'b0;
    irq_next = |(ist_next & imask_next);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= vtp_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= vtp_pkg::RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
      awa_reg <= 8'h00;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      ctrl_reg <= vtp_pkg::CTRL_RST;
      base_reg <= 32'h0000_0000;
      imask_reg <= 2'h0;
      ist_reg <= 2'h0;
      frames_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      ctrl_reg <= ctrl_next;
      base_reg <= base_next;
      imask_reg <= imask_next;
      ist_reg <= ist_next;
      frames_reg <= frames_next;
      irq_reg <= irq_next;
    end
  end

  assign s_awready = awready_reg;
  assign s_wready = wready_reg;
  assign s_bvalid = bvalid_reg;
  assign s_bresp = bresp_reg;
  assign s_arready = arready_reg;
  assign s_rvalid = rvalid_reg;
  assign s_rresp = rresp_reg;
  assign s_rdata = rdata_reg;
  assign timing_out = tim_reg;
  assign video_data = vd_reg;
  assign mem_wvalid = mwv_reg;
  assign mem_waddr = mwa_reg;
  assign mem_wdata = mwd_reg;
  assign irq = irq_reg;

endmodule

// >>> video_timing_pattern_capture_checker.sv
`timescale 1ns/1ps
module video_timing_pattern_capture_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Timing and pixel stream
  input wire vtp_pkg::timing_t timing_out,
  input wire logic [vtp_pkg::BEAT_W-1:0] video_data,
  // Memory write port
  input wire logic mem_wvalid,
  input wire logic [31:0] mem_waddr,
  input wire logic [vtp_pkg::MEM_W-1:0] mem_wdata,
  input wire logic mem_wready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Eight beats is below the shortest porch or pulse of any mode
  sequence s_front;
    (!timing_out.hsync && !timing_out.de) [*8];
  endsequence
  sequence s_sync;
    (timing_out.hsync && timing_out.hblank) [*8];
  endsequence
  sequence s_back;
    (!timing_out.hsync && !timing_out.de) [*8];
  endsequence

  property p_pad;
    video_data[47:40] == 8'h00 && video_data[23:16] == 8'h00;
  endproperty
  property p_blank_data;
    !timing_out.de |-> video_data == 48'h0;
  endproperty
  property p_de_active;
    timing_out.de |-> !timing_out.hblank && !timing_out.vblank;
  endproperty
  property p_hsync_blank;
    timing_out.hsync |-> timing_out.hblank;
  endproperty
  property p_front;
    $fell(timing_out.de) |-> s_front;
  endproperty
  property p_sync;
    $rose(timing_out.hsync) |-> s_sync;
  endproperty
  property p_back;
    $fell(timing_out.hsync) |-> s_back;
  endproperty
  property p_mem_hold;
    mem_wvalid && !mem_wready |=>
      mem_wvalid && $stable(mem_waddr) && $stable(mem_wdata);
  endproperty
  property p_marks;
    timing_out.sof || timing_out.eol |-> timing_out.de;
  endproperty
  // Memory word is the beat repacked as Y0 Cb Y1 Cr
  property p_yuyv;
    mem_wvalid |-> timing_out.de &&
      mem_wdata == {video_data[39:24], video_data[15:0]};
  endproperty

  a_pad: assert property (p_pad)
    else $error("pad byte not zero");
  a_blank_data: assert property (p_blank_data)
    else $error("pixel data outside active video");
  a_de_active: assert property (p_de_active)
    else $error("data enable during blanking");
  a_hsync_blank: assert property (p_hsync_blank)
    else $error("hsync outside horizontal blanking");
  a_front: assert property (p_front)
    else $error("front porch too short");
  a_sync: assert property (p_sync)
    else $error("sync pulse too short");
  a_back: assert property (p_back)
    else $error("back porch too short");
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory write changed while stalled");
  a_marks: assert property (p_marks)
    else $error("frame or line mark without data enable");
  a_yuyv: assert property (p_yuyv)
    else $error("memory word not packed from the current beat");
endmodule

// >>> mem_sink.sv
`timescale 1ns/1ps
module mem_sink (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bench control
  input wire logic stall_en,
  input wire logic [31:0] base,
  // Memory write port
  input wire logic mem_wvalid,
  input wire logic [31:0] mem_waddr,
  output logic mem_wready,
  // Results
  output logic [31:0] writes,
  output logic [31:0] errs
);
  logic [31:0] last;
  logic [1:0] tick;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_wready <= 1'b1;
      writes <= 32'h0;
      errs <= 32'h0;
      last <= 32'h0;
      tick <= 2'h0;
    end else begin
      tick <= (tick == 2'h2) ? 2'h0 : tick + 2'h1;
      // Refuses one edge in three so the writer must hold
      mem_wready <= !stall_en || tick != 2'h1;
      if (mem_wvalid && mem_wready) begin
        writes <= writes + 32'h1;
        last <= mem_waddr;
        // Restart at base, else words stay packed one after another
        if (mem_waddr != base && mem_waddr != last + 32'h4) begin
          errs <= errs + 32'h1;
        end
      end
    end
  end
endmodule

// >>> video_timing_pattern_capture_tb.sv
`timescale 1ns/1ps
module video_timing_pattern_capture_tb;
  typedef struct {
    vtp_pkg::mode_t mode;
    int a, f, s, b;
  } row_t;
  logic mclk, rst, gpio_rst, stall_en, irq;
  logic [7:0] s_awaddr, s_araddr;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [31:0] s_wdata, s_rdata, mem_waddr, writes, errs, rd, ctl;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rsp;
  vtp_pkg::timing_t timing_out;
  logic [vtp_pkg::BEAT_W-1:0] video_data;
  logic [vtp_pkg::MEM_W-1:0] mem_wdata;
  logic mem_wvalid, mem_wready;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int n [4];
  int k;
  // Beats per phase: two pixels move per clock
  row_t rows [4] = '{'{vtp_pkg::MODE_720P60, 640, 55, 20, 110},
                     '{vtp_pkg::MODE_1080P60, 960, 44, 22, 74},
                     '{vtp_pkg::MODE_2160P30, 1920, 88, 44, 148},
                     '{vtp_pkg::MODE_2160P60, 1920, 88, 44, 148}};

  video_timing_pattern_capture dut (.*);
  mem_sink sink (.mclk(mclk), .rst(rst), .stall_en(stall_en),
    .base(32'h1000_0000), .mem_wvalid(mem_wvalid), .mem_waddr(mem_waddr),
    .mem_wready(mem_wready), .writes(writes), .errs(errs));

  // Bench clock stands in for the programmed pixel clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      $display("mismatch at %0t: timeout", $time);
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    rsp = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic rd32(input logic [7:0] a);
    @(posedge mclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    rd = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
  endtask

  // Counts beats while one timing bit keeps a level, sampled mid-cycle
  task automatic run(input int i, input logic v, output int c);
    c = 0;
    while (timing_out[i] === v) begin
      c++;
      @(negedge mclk);
    end
  endtask

  initial begin
    rst = 1'b1;
    gpio_rst = 1'b0;
    stall_en = 1'b0;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_awvalid = 1'b0;
    s_wvalid = 1'b0;
    s_bready = 1'b0;
    s_arvalid = 1'b0;
    s_rready = 1'b0;
    s_wdata = 32'h0;
    s_wstrb = 4'hF;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    wr(vtp_pkg::REG_FB_BASE, 32'h1000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(vtp_pkg::REG_CTRL, 32'h0);
      gpio_rst <= 1'b1;
      repeat (4) @(posedge mclk);
      gpio_rst <= 1'b0;
      repeat (4) @(posedge mclk);
      ctl = {26'h0, 2'(i), 1'b0, rows[i].mode, 1'b1};
      wr(vtp_pkg::REG_CTRL, ctl);
      rd32(vtp_pkg::REG_CTRL);
      cmp(rd, ctl);
      @(negedge mclk);
      run(2, 1'b1, n[0]);
      run(2, 1'b0, n[0]);
      run(2, 1'b1, n[0]);
      run(6, 1'b0, n[1]);
      run(6, 1'b1, n[2]);
      run(2, 1'b0, n[3]);
      cmp(n[0], rows[i].a);
      cmp(n[1], rows[i].f);
      cmp(n[2], rows[i].s);
      cmp(n[3], rows[i].b);
    end
    rd32(vtp_pkg::REG_STATUS);
    cmp(rd & 32'h1, 32'h1);
    wr(8'h40, 32'hFFFF_FFFF);
    cmp(rsp, vtp_pkg::RESP_SLVERR);
    rd32(8'h40);
    cmp(rd, 32'h0);
    cmp(rsp, vtp_pkg::RESP_SLVERR);
    wr(vtp_pkg::REG_IRQ_MASK, 32'h3);
    rd32(vtp_pkg::REG_IRQ_MASK);
    cmp(rd, 32'h3);
    wr(vtp_pkg::REG_IRQ_STAT, 32'h3);
    rd32(vtp_pkg::REG_IRQ_STAT);
    cmp(rd, 32'h0);
    cmp(irq, 1'b0);
    // Writer keeps going while memory refuses every third edge
    stall_en <= 1'b1;
    repeat (3000) @(posedge mclk);
    cmp(errs, 32'h0);
    cmp(32'(writes > 32'h0), 32'h1);
    // Land the reset in active video so no sync pulse is cut short
    while (timing_out.de !== 1'b1) @(posedge mclk);
    stall_en <= 1'b0;
    gpio_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    k = 0;
    repeat (2400) begin
      @(posedge mclk);
      if (timing_out.de !== 1'b0) k++;
    end
    cmp(k, 0);
    gpio_rst <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd32(vtp_pkg::REG_CTRL);
    cmp(rd, vtp_pkg::CTRL_RST);
    rd32(vtp_pkg::REG_IRQ_MASK);
    cmp(rd, 32'h0);
    rd32(vtp_pkg::REG_FRAMES);
    cmp(rd, 32'h0);
    finish_test();
  end
endmodule

bind video_timing_pattern_capture video_timing_pattern_capture_checker chk (
  .mclk(mclk), .rst(rst), .timing_out(timing_out), .video_data(video_data),
  .mem_wvalid(mem_wvalid), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
  .mem_wready(mem_wready));
